/* design/acr_top.sv */
// Audio clock control: APB registers, reference divider, N/CTS regeneration,
// digital cleaner and bit clock / word select generation.
// Assumes oscillator ticks and pin inputs are synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module acr_top #(
  parameter int ADDR_W   = 8,
  parameter int PERIOD_W = 16
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  // APB slave
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  // Reference ticks
  input  wire logic              link_pll_oscillator_clock,
  input  wire logic              always_on_oscillator,
  // Audio pins
  input  wire logic              sclk_in,
  output logic                   sclk_out,
  output logic                   sclk_oe,
  input  wire logic              ws_in,
  output logic                   ws_out,
  output logic                   ws_oe,
  output logic                   mclk_out
);

  // ----------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------
  if (ADDR_W < 8 || PERIOD_W < 4 || PERIOD_W > 24) begin : g_bad_param
    $error("acr_top: ADDR_W must be at least 8 and PERIOD_W within 4..24");
  end

  // ----------------------------------------------------------------------
  // Registers and bus decode
  // ----------------------------------------------------------------------
  acr_pkg::acr_ctrl_s  ctrl_reg;
  logic [23:0]         cts_reg;
  logic [19:0]         n_reg;
  logic [3:0]          loop_filter_shift;
  logic [31:0]         prdata_reg;
  logic [31:0]         rd_next;
  logic [ADDR_W-3:0]   widx;
  logic                hit;
  logic                wr_en;
  acr_pkg::acr_sts_s   sts;
  logic [2:0]          input_queue_fill;
  logic [2:0]          output_queue_fill;

  assign widx    = paddr[ADDR_W-1:2];
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite && pready && hit;
  assign pslverr = psel && penable && !hit;
  assign prdata  = prdata_reg;
  assign sts     = '{reserved: 2'h0, input_queue_fill: input_queue_fill,
                     output_queue_fill: output_queue_fill};

  always_comb begin
    hit     = (paddr[1:0] == 2'h0);
    rd_next = 32'h0000_0000;
    unique case (widx)
      (ADDR_W-2)'(acr_pkg::IDX_CTRL):   rd_next[7:0] = ctrl_reg;
      (ADDR_W-2)'(acr_pkg::IDX_CTS_LO): rd_next[7:0] = cts_reg[7:0];
      (ADDR_W-2)'(acr_pkg::IDX_CTS_MI): rd_next[7:0] = cts_reg[15:8];
      (ADDR_W-2)'(acr_pkg::IDX_CTS_HI): rd_next[7:0] = cts_reg[23:16];
      (ADDR_W-2)'(acr_pkg::IDX_N_LO):   rd_next[7:0] = n_reg[7:0];
      (ADDR_W-2)'(acr_pkg::IDX_N_MI):   rd_next[7:0] = n_reg[15:8];
      (ADDR_W-2)'(acr_pkg::IDX_N_HI):   rd_next[7:0] = {loop_filter_shift, n_reg[19:16]};
      (ADDR_W-2)'(acr_pkg::IDX_STS):    rd_next[7:0] = sts;
      default:                          hit = 1'b0;
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= rd_next;
    end
  end

  // Control register
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= acr_pkg::acr_ctrl_s'(acr_pkg::RST_CTRL);
    end else if (wr_en && widx == (ADDR_W-2)'(acr_pkg::IDX_CTRL)) begin
      ctrl_reg <= acr_pkg::acr_ctrl_s'(pwdata[7:0]);
    end
  end

  // CTS, N and loop filter shift; status writes fall through
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cts_reg           <= acr_pkg::RST_CTS;
      n_reg             <= acr_pkg::RST_N;
      loop_filter_shift <= acr_pkg::RST_SHFT;
    end else if (wr_en) begin
      if (widx == (ADDR_W-2)'(acr_pkg::IDX_CTS_LO)) begin
        cts_reg[7:0] <= pwdata[7:0];
      end
      if (widx == (ADDR_W-2)'(acr_pkg::IDX_CTS_MI)) begin
        cts_reg[15:8] <= pwdata[7:0];
      end
      if (widx == (ADDR_W-2)'(acr_pkg::IDX_CTS_HI)) begin
        cts_reg[23:16] <= pwdata[7:0];
      end
      if (widx == (ADDR_W-2)'(acr_pkg::IDX_N_LO)) begin
        n_reg[7:0] <= pwdata[7:0];
      end
      if (widx == (ADDR_W-2)'(acr_pkg::IDX_N_MI)) begin
        n_reg[15:8] <= pwdata[7:0];
      end
      if (widx == (ADDR_W-2)'(acr_pkg::IDX_N_HI)) begin
        n_reg[19:16]      <= pwdata[3:0];
        loop_filter_shift <= pwdata[7:4];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Cleaner reference divider
  // ----------------------------------------------------------------------
  logic [2:0] div_cnt_reg;
  logic [2:0] div_last;
  logic       ref_tick;

  always_comb begin
    unique case (ctrl_reg.ref_sel)
      acr_pkg::REF_DIV8: div_last = acr_pkg::DIV8_LAST;
      acr_pkg::REF_DIV4: div_last = acr_pkg::DIV4_LAST;
      acr_pkg::REF_DIV2: div_last = acr_pkg::DIV2_LAST;
      acr_pkg::REF_AON:  div_last = acr_pkg::DIV2_LAST;
    endcase
    if (ctrl_reg.ref_sel == acr_pkg::REF_AON) begin
      ref_tick = always_on_oscillator;
    end else begin
      ref_tick = link_pll_oscillator_clock && (div_cnt_reg >= div_last);
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt_reg <= 3'h0;
    end else if (link_pll_oscillator_clock) begin
      div_cnt_reg <= (div_cnt_reg >= div_last) ? 3'h0 : 3'(div_cnt_reg + 3'h1);
    end
  end

  // ----------------------------------------------------------------------
  // N/CTS regeneration
  // ----------------------------------------------------------------------
  logic        regen_on;
  logic [24:0] acc_reg;
  logic [24:0] acc_sum;
  logic [24:0] acc_next;
  logic        regen_tick;

  assign regen_on = (cts_reg != 24'h000000) && (n_reg != 20'h00000);

  always_comb begin
    acc_sum    = 25'(acc_reg + {5'h00, n_reg});
    regen_tick = regen_on && ref_tick && (acc_sum >= {1'b0, cts_reg});
    acc_next   = regen_tick ? 25'(acc_sum - {1'b0, cts_reg}) : acc_sum;
    if (acc_next >= {1'b0, cts_reg}) begin
      acc_next = 25'({1'b0, cts_reg} - 25'h1);
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_reg <= 25'h0;
    end else if (!regen_on) begin
      acc_reg <= 25'h0;
    end else if (ref_tick) begin
      acc_reg <= acc_next;
    end
  end

  // ----------------------------------------------------------------------
  // Audio source select
  // ----------------------------------------------------------------------
  logic sclk_in_d;
  logic src_tick;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_in_d <= 1'b0;
    end else begin
      sclk_in_d <= sclk_in;
    end
  end

  always_comb begin
    if (regen_on) begin
      src_tick = regen_tick;
    end else if (ctrl_reg.master) begin
      src_tick = ref_tick;
    end else begin
      src_tick = sclk_in && !sclk_in_d;
    end
  end

  // ----------------------------------------------------------------------
  // Digital cleaner
  // ----------------------------------------------------------------------
  logic                       clean_on;
  logic [1:0]                 ratio_shift;
  logic [1:0]                 sub_last;
  logic [1:0]                 sub_reg;
  logic [PERIOD_W-1:0]        per_cnt_reg;
  logic [PERIOD_W-1:0]        est_reg;
  logic [PERIOD_W-1:0]        gen_cnt_reg;
  logic [PERIOD_W-1:0]        step;
  logic signed [PERIOD_W:0]   err;
  logic signed [PERIOD_W:0]   err_shift;
  logic                       emit;
  logic                       in_push;
  logic                       in_pop;
  logic                       base_tick;

  assign clean_on    = (ctrl_reg.clean_mode != 2'h0);
  assign ratio_shift = 2'(ctrl_reg.clean_mode - 2'h1);
  assign sub_last    = 2'((3'h1 << ratio_shift) - 3'h1);
  assign step        = est_reg >> ratio_shift;
  assign err         = $signed({1'b0, per_cnt_reg}) - $signed({1'b0, est_reg});
  assign err_shift   = err >>> loop_filter_shift;
  assign emit        = clean_on && ref_tick && (input_queue_fill != 3'h0)
                       && (gen_cnt_reg >= step);
  assign in_push     = clean_on && src_tick && (input_queue_fill != acr_pkg::FILL_FULL);
  assign in_pop      = emit && (sub_reg == sub_last);
  assign base_tick   = clean_on ? (output_queue_fill != 3'h0) : src_tick;

  // Period measurement and loop filter
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      per_cnt_reg <= '0;
      est_reg     <= '0;
    end else if (!clean_on) begin
      per_cnt_reg <= '0;
      est_reg     <= '0;
    end else if (src_tick) begin
      per_cnt_reg <= '0;
      est_reg     <= PERIOD_W'(est_reg + err_shift[PERIOD_W-1:0]);
    end else if (ref_tick && per_cnt_reg != '1) begin
      per_cnt_reg <= PERIOD_W'(per_cnt_reg + 1'b1);
    end
  end

  // Output tick generator, ratio emissions per input
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gen_cnt_reg <= '0;
      sub_reg     <= 2'h0;
    end else if (!clean_on) begin
      gen_cnt_reg <= '0;
      sub_reg     <= 2'h0;
    end else if (ref_tick) begin
      if (emit) begin
        gen_cnt_reg <= '0;
        sub_reg     <= (sub_reg == sub_last) ? 2'h0 : 2'(sub_reg + 2'h1);
      end else if (gen_cnt_reg != '1) begin
        gen_cnt_reg <= PERIOD_W'(gen_cnt_reg + 1'b1);
      end
    end
  end

  // Queue fill levels
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      input_queue_fill  <= 3'h0;
      output_queue_fill <= 3'h0;
    end else if (!clean_on) begin
      input_queue_fill  <= 3'h0;
      output_queue_fill <= 3'h0;
    end else begin
      input_queue_fill  <= 3'(input_queue_fill + {2'h0, in_push} - {2'h0, in_pop});
      output_queue_fill <= 3'(output_queue_fill + {2'h0, emit}
                           - {2'h0, (output_queue_fill != 3'h0)});
    end
  end

  // ----------------------------------------------------------------------
  // Master, bit and word clock generation
  // ----------------------------------------------------------------------
  logic       mclk_reg;
  logic       sclk_reg;
  logic       ws_reg;
  logic [2:0] mclk_cnt_reg;
  logic [2:0] mult_last;
  logic [5:0] bit_cnt_reg;
  logic [5:0] half_last;
  logic       sclk_fall;

  always_comb begin
    unique case (ctrl_reg.mclk_ratio)
      2'h0: mult_last = acr_pkg::MUL4_LAST;
      2'h1: mult_last = acr_pkg::MUL2_LAST;
      2'h2: mult_last = acr_pkg::MUL1_LAST;
      2'h3: mult_last = acr_pkg::MUL8_LAST;
    endcase
  end

  assign half_last = ctrl_reg.ws_ratio_32 ? acr_pkg::HALF32_LAST : acr_pkg::HALF64_LAST;
  assign sclk_fall = base_tick && sclk_reg && (mclk_cnt_reg == mult_last);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mclk_reg <= 1'b0;
    end else if (!ctrl_reg.master) begin
      mclk_reg <= 1'b0;
    end else if (base_tick) begin
      mclk_reg <= !mclk_reg;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mclk_cnt_reg <= 3'h0;
      sclk_reg     <= 1'b0;
    end else if (!ctrl_reg.master) begin
      mclk_cnt_reg <= 3'h0;
      sclk_reg     <= 1'b0;
    end else if (base_tick) begin
      if (mclk_cnt_reg >= mult_last) begin
        mclk_cnt_reg <= 3'h0;
        sclk_reg     <= !sclk_reg;
      end else begin
        mclk_cnt_reg <= 3'(mclk_cnt_reg + 3'h1);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_cnt_reg <= 6'h00;
      ws_reg      <= 1'b0;
    end else if (!ctrl_reg.master) begin
      bit_cnt_reg <= 6'h00;
      ws_reg      <= 1'b0;
    end else if (sclk_fall) begin
      if (bit_cnt_reg >= half_last) begin
        bit_cnt_reg <= 6'h00;
        ws_reg      <= !ws_reg;
      end else begin
        bit_cnt_reg <= 6'(bit_cnt_reg + 6'h01);
      end
    end
  end

  assign mclk_out = mclk_reg;
  assign sclk_out = sclk_reg;
  assign ws_out   = ws_reg;
  assign sclk_oe  = ctrl_reg.master;
  assign ws_oe    = ctrl_reg.master;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  word_period_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ($changed(ws_reg) && $past(ctrl_reg.master) && ctrl_reg.master)
      |-> ($past(bit_cnt_reg) >= $past(half_last)) && $past(sclk_fall))
    else $error("word select toggled at wrong bit count");

  bit_ratio_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ($changed(sclk_reg) && $past(ctrl_reg.master) && ctrl_reg.master)
      |-> $past(base_tick) && ($past(mclk_cnt_reg) >= $past(mult_last)))
    else $error("bit clock toggled at wrong master count");

  ref_divide_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ref_tick && ctrl_reg.ref_sel == acr_pkg::REF_DIV8)
      |-> link_pll_oscillator_clock && div_cnt_reg == 3'h7)
    else $error("reference tick not on eighth oscillator tick");

  clean_bypass_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ctrl_reg.clean_mode == 2'h0) |-> (base_tick == src_tick)
      && ($past(ctrl_reg.clean_mode) != 2'h0 || output_queue_fill == 3'h0))
    else $error("cleaner active while clean mode is off");

  pins_master_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !ctrl_reg.master |-> (!sclk_oe && !ws_oe) ##1 (!sclk_out && !ws_out && !mclk_out))
    else $error("audio pins driven in slave mode");

  regen_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cts_reg == 24'h000000 || n_reg == 20'h00000) |-> !regen_tick ##1 acc_reg == 25'h0)
    else $error("regeneration running with zero N or CTS");

  filter_step_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (clean_on && src_tick && $stable(ctrl_reg.clean_mode))
      |=> est_reg == PERIOD_W'($past(est_reg) + $past(err_shift[PERIOD_W-1:0])))
    else $error("loop filter estimate step wrong");

  status_read_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (psel && !penable && !pwrite && widx == (ADDR_W-2)'(acr_pkg::IDX_STS) && hit)
      |=> prdata[5:3] == $past(input_queue_fill) && prdata[2:0] == $past(output_queue_fill))
    else $error("status read does not show queue fills");

  out_fill_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (clean_on && $past(clean_on) && !$past(emit) && $past(output_queue_fill) != 3'h0)
      |-> output_queue_fill == 3'($past(output_queue_fill) - 3'h1))
    else $error("output queue fill did not drain");

  status_reserved_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (psel && !penable && !pwrite && widx == (ADDR_W-2)'(acr_pkg::IDX_STS) && hit)
      |=> prdata[31:6] == 26'h0)
    else $error("status reserved bits not zero");

endmodule : acr_top
`default_nettype wire

/* design/acr_pkg.sv */
// Constants, field layouts and reset values for the audio clock control block.
// Assumes an APB master with 32-bit data; registers sit in the low byte of a word.
package acr_pkg;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL   = 8'h30;
  localparam logic [7:0] IDX_CTS_LO = 8'h31;
  localparam logic [7:0] IDX_CTS_MI = 8'h32;
  localparam logic [7:0] IDX_CTS_HI = 8'h33;
  localparam logic [7:0] IDX_N_LO   = 8'h34;
  localparam logic [7:0] IDX_N_MI   = 8'h35;
  localparam logic [7:0] IDX_N_HI   = 8'h36;
  localparam logic [7:0] IDX_STS    = 8'h37;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  RST_CTRL = 8'h00;
  localparam logic [23:0] RST_CTS  = 24'h000000;
  localparam logic [19:0] RST_N    = 20'h00000;
  localparam logic [3:0]  RST_SHFT = 4'h0;

  // ----------------------------------------------------------------------
  // Field codes and counts
  // ----------------------------------------------------------------------
  localparam logic [1:0] REF_DIV8 = 2'h0;
  localparam logic [1:0] REF_DIV4 = 2'h1;
  localparam logic [1:0] REF_DIV2 = 2'h2;
  localparam logic [1:0] REF_AON  = 2'h3;
  localparam logic [2:0] DIV8_LAST = 3'h7;
  localparam logic [2:0] DIV4_LAST = 3'h3;
  localparam logic [2:0] DIV2_LAST = 3'h1;
  localparam logic [2:0] MUL4_LAST = 3'h3;
  localparam logic [2:0] MUL2_LAST = 3'h1;
  localparam logic [2:0] MUL1_LAST = 3'h0;
  localparam logic [2:0] MUL8_LAST = 3'h7;
  localparam logic [5:0] HALF64_LAST = 6'h1F;
  localparam logic [5:0] HALF32_LAST = 6'h0F;
  localparam logic [2:0] FILL_FULL   = 3'h7;

  // ----------------------------------------------------------------------
  // Control and status register layouts
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       ws_ratio_32;
    logic [1:0] mclk_ratio;
    logic [1:0] ref_sel;
    logic [1:0] clean_mode;
    logic       master;
  } acr_ctrl_s;

  typedef struct packed {
    logic [1:0] reserved;
    logic [2:0] input_queue_fill;
    logic [2:0] output_queue_fill;
  } acr_sts_s;

endpackage : acr_pkg

/* tb/acr_peer.sv */
// Audio serial peer model: drives bit clock and word select towards the block.
// Assumes the bench resolves each pin from the block's output enables.
`timescale 1ns/1ps
`default_nettype none
module acr_peer #(
  parameter int HALF = 3
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Frame control
  input  wire logic active,
  // Pin drive
  output var  logic sclk_drv,
  output var  logic ws_drv
);
  int ph;
  int bits;

  // ----------------------------------------------------------------------
  // Bit clock within frames only, still between them
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ph       <= 0;
      bits     <= 0;
      sclk_drv <= 1'b0;
      ws_drv   <= 1'b0;
    end else if (active) begin
      ph <= (ph == HALF - 1) ? 0 : ph + 1;
      if (ph == HALF - 1) begin
        sclk_drv <= ~sclk_drv;
        if (sclk_drv) begin
          bits   <= (bits == 31) ? 0 : bits + 1;
          ws_drv <= (bits == 31) ? ~ws_drv : ws_drv;
        end
      end
    end
  end
endmodule : acr_peer
`default_nettype wire

/* tb/test_audio_clock_regen_control.sv */
// Self-checking bench for the audio clock control block.
// Assumes one 10 MHz clock; oscillator ticks are made here on that clock.
`timescale 1ns/1ps
`default_nettype none
module test_audio_clock_regen_control;
  logic        sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic        osc_tick, aon_tick, peer_on, sclk_drv, ws_drv;
  logic        sclk_out, sclk_oe, ws_out, ws_oe, mclk_out;
  logic [2:0]  seen;
  int          err_total, n_compared, cyc, base, lo;
  int          cnt [4];
  int          mult [4] = '{4, 2, 1, 8};
  int          divs [4] = '{8, 4, 2, 3};

  acr_top #(.ADDR_W(8), .PERIOD_W(8)) dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_pll_oscillator_clock(osc_tick),
    .always_on_oscillator(aon_tick), .sclk_in(sclk_oe ? sclk_out : sclk_drv),
    .sclk_out(sclk_out), .sclk_oe(sclk_oe), .ws_in(ws_oe ? ws_out : ws_drv),
    .ws_out(ws_out), .ws_oe(ws_oe), .mclk_out(mclk_out));

  acr_peer #(.HALF(3)) peer (.sys_clk(sys_clk), .sys_rst(sys_rst), .active(peer_on),
    .sclk_drv(sclk_drv), .ws_drv(ws_drv));

  always #50 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------------
  // Ticks, edge counters and timeout
  // ----------------------------------------------------------------------
  always @(posedge sys_clk) begin
    cyc      <= cyc + 1;
    osc_tick <= 1'b1;
    aon_tick <= (cyc % 3 == 0);
    seen     <= {mclk_out, sclk_out, ws_out};
    cnt[0]   <= cnt[0] + 1;
    cnt[1]   <= cnt[1] + int'(mclk_out != seen[2]);
    cnt[2]   <= cnt[2] + int'(sclk_out != seen[1]);
    cnt[3]   <= cnt[3] + int'(ws_out != seen[0]);
    if (cyc == 60000) begin
      err_total++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // APB transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx[5:0], 2'b00};
    pwdata  <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  // Toggles of counter m across one toggle interval of counter r
  task automatic span(input int r, input int m, input int exp);
    for (int k = 0; k < 3; k++) begin
      lo = cnt[r];
      if (k == 2) base = cnt[m];
      wait (cnt[r] != lo);
      #1;
    end
    chk(32'(cnt[m] - base), 32'(exp));
  endtask : span

  task automatic conclude();
    if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // Master clock toggles in 400 cycles: 25 inputs times the cleaning ratio
  function automatic int clean_exp(input int c);
    return 25 * (1 << (c - 1));
  endfunction : clean_exp

  initial begin
    {sys_clk, psel, penable, pwrite, paddr, pwdata, osc_tick, aon_tick, peer_on} = '0;
    {err_total, n_compared, cyc, seen} = '0;
    cnt = '{default: 0};
    sys_rst = 1'b1;
    v = $urandom(13104);
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // Reset values, then random write and read back
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, acr_pkg::IDX_CTRL + 8'(i), 8'h00);
      chk(rd, 32'h0);
    end
    for (int i = 0; i < 7; i++) begin
      v = $urandom;
      apb(1'b1, acr_pkg::IDX_CTRL + 8'(i), v[7:0]);
      apb(1'b0, acr_pkg::IDX_CTRL + 8'(i), 8'h00);
      chk(rd, {24'h0, v[7:0]});
    end
    for (int i = 0; i < 7; i++) apb(1'b1, acr_pkg::IDX_CTRL + 8'(i), 8'h00);
    // Status ignores writes; unmapped index refused
    apb(1'b1, acr_pkg::IDX_STS, 8'hFF);
    apb(1'b0, acr_pkg::IDX_STS, 8'h00);
    chk(rd, 32'h0);
    apb(1'b1, 8'h38, 8'h01);
    chk(32'(er), 32'h1);
    // Master clock ratio codes
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, acr_pkg::IDX_CTRL, {1'b0, 2'(c), 2'h2, 2'h0, 1'b1});
      chk({30'h0, sclk_oe, ws_oe}, 32'h3);
      span(2, 1, mult[c]);
    end
    // Reference select codes
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, acr_pkg::IDX_CTRL, {1'b0, 2'h2, 2'(c), 2'h0, 1'b1});
      span(1, 0, divs[c]);
    end
    // Bits per word-select period
    for (int c = 0; c < 2; c++) begin
      apb(1'b1, acr_pkg::IDX_CTRL, {1'(c), 2'h2, 2'h2, 2'h0, 1'b1});
      span(3, 2, c ? 32 : 64);
    end
    // Regeneration: N=1, CTS=3 gives one tick per three reference ticks
    apb(1'b1, acr_pkg::IDX_N_LO, 8'h01);
    apb(1'b1, acr_pkg::IDX_CTS_LO, 8'h03);
    apb(1'b1, acr_pkg::IDX_CTRL, {1'b0, 2'h2, 2'h2, 2'h0, 1'b1});
    span(1, 0, 6);
    apb(1'b1, acr_pkg::IDX_CTS_LO, 8'h00);
    span(1, 0, 2);
    // Cleaner ratios on a regenerated source, one input per eight reference ticks
    apb(1'b1, acr_pkg::IDX_CTS_LO, 8'h08);
    for (int c = 1; c < 4; c++) begin
      apb(1'b1, acr_pkg::IDX_CTRL, {1'b0, 2'h2, 2'h2, 2'(c), 1'b1});
      repeat (100) @(posedge sys_clk);
      base = cnt[1];
      repeat (400) @(posedge sys_clk);
      lo = clean_exp(c);
      chk(32'(cnt[1] - base >= lo - 4 && cnt[1] - base <= lo + 4), 32'h1);
      apb(1'b0, acr_pkg::IDX_STS, 8'h00);
      chk({24'h0, rd[7:6]}, 32'h0);
    end
    // Slave mode: pins released, peer drives the bit clock
    apb(1'b1, acr_pkg::IDX_CTRL, 8'h00);
    peer_on <= 1'b1;
    repeat (40) @(posedge sys_clk);
    chk({29'h0, sclk_oe, ws_oe, mclk_out}, 32'h0);
    conclude();
  end
endmodule : test_audio_clock_regen_control
`default_nettype wire
